// [lbm_defs.svh]
`ifndef LBM_DEFS_SVH
`define LBM_DEFS_SVH

// ==========================================================
// Register offsets in the 32-byte slave space
`define LBM_ADDR_W          5
`define LBM_OFF_SWRESET     5'h14
`define LBM_OFF_BLCTRL      5'h18
`define LBM_OFF_ARBCTRL     5'h1C

// ==========================================================
// Field positions and reset values
`define LBM_CLL_MSB         15
`define LBM_CLL_LSB         11
`define LBM_LINEAR_BURST_COUNT_MSB       2
`define LBM_LINEAR_BURST_COUNT_LSB       0
`define LBM_BLCTRL_RST      16'h2000
`define LBM_ARB_PRIO_BIT    0
`define LBM_ARB_STOP_BIT    1
`define LBM_ARBCTRL_RST     16'h0000
`define LBM_STAT_HOLD_BIT   8
`define LBM_STAT_HLDA_BIT   9

// ==========================================================
// Line length codes
`define LBM_CLL_NONE        5'h00
`define LBM_CLL_A2          5'h01
`define LBM_CLL_A3          5'h02
`define LBM_CLL_A4          5'h04
`define LBM_CLL_A5          5'h08
`define LBM_CLL_A6          5'h10

// ==========================================================
// Synchroniser bit positions
`define LBM_NSYNC           8
`define LBM_SY_RESET        0
`define LBM_SY_GRANT        1
`define LBM_SY_RDYRTN       2
`define LBM_SY_BRDY         3
`define LBM_SY_BOFF         4
`define LBM_SY_AHOLD        5
`define LBM_SY_CHREQ        6
`define LBM_SY_VLMODE       7

// ==========================================================
// Timing
`define LBM_RESET_HOLD_MAX_CYC 6

`endif

// [lbm_pkg.sv]
package lbm_pkg;

  // ==========================================================
  // Machine states
  typedef enum logic [2:0] {
    M_IDLE,
    M_REQ,
    M_ADDR,
    M_DATA,
    M_BOFF,
    M_DROP,
    M_CHAIN
  } lbm_mstate_e;

  typedef enum logic [0:0] {
    S_IDLE,
    S_ACK
  } lbm_sstate_e;

  // ==========================================================
  // One higher-level operation: one or two basic transfers
  typedef struct packed {
    logic        write;
    logic        linear;
    logic        two;
    logic [29:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata0;
    logic [31:0] wdata1;
  } lbm_op_s;

endpackage : lbm_pkg

// [lbm_bus_master.sv]
`include "lbm_defs.svh"

module lbm_bus_master (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Slave register port
  input  wire logic             slv_sel,
  input  wire logic             slv_rd,
  input  wire logic             slv_wr,
  input  wire logic [4:0]       slv_addr,
  input  wire logic [15:0]      slv_wdata,
  output logic      [15:0]      slv_rdata,
  output logic                  slv_rdy_n,
  output logic                  slv_rdy_oe,
  output logic                  slv_claim,
  // Operation request from buffer management
  input  wire logic             op_valid,
  input  wire lbm_pkg::lbm_op_s op,
  input  wire logic             preempt,
  output logic                  op_ack,
  output logic                  op_done,
  output logic      [31:0]      rd_data,
  output logic                  rd_valid,
  // Arbitration pins
  input  wire logic             hw_reset_pin,
  input  wire logic             vl_mode_pin,
  input  wire logic             grant_pin,
  output logic                  hold_pin,
  input  wire logic             chained_hold_request_in,
  output logic                  chained_hold_ack_out,
  // Cycle control pins
  input  wire logic             rdyrtn_n,
  input  wire logic             brdy_n,
  input  wire logic             boff_n,
  input  wire logic             ahold,
  output logic                  ads_n,
  output logic                  wr_out,
  output logic      [3:0]       be_n_out,
  output logic                  ctl_oe,
  // Address and data pins
  output logic      [31:2]      addr_out,
  output logic      [31:2]      addr_oe,
  output logic      [31:0]      data_out,
  output logic                  data_oe,
  input  wire logic [31:0]      data_in
);

  // ==========================================================
  // Decoders
  function automatic logic [29:0] float_mask(input logic [4:0] cache_line_length);
    logic [29:0] m;
    m = 30'h0;
    case (cache_line_length)
      `LBM_CLL_A2: m = 30'h3FFFFFFF;
      `LBM_CLL_A3: m = 30'h3FFFFFFE;
      `LBM_CLL_A4: m = 30'h3FFFFFFC;
      `LBM_CLL_A5: m = 30'h3FFFFFF8;
      `LBM_CLL_A6: m = 30'h3FFFFFF0;
      default:     m = 30'h0;
    endcase
    return m;
  endfunction : float_mask

  function automatic logic [29:0] low_group(input logic [2:0] lbc);
    logic [29:0] m;
    m = 30'h0;
    for (int i = 0; i < 8; i++)
      if (i < int'(lbc))
        m[i] = 1'b1;
    return m;
  endfunction : low_group

  // ==========================================================
  // Input synchronisers
  logic [`LBM_NSYNC-1:0] sy_in;
  logic [`LBM_NSYNC-1:0] sy_a;
  logic [`LBM_NSYNC-1:0] sy_b;
  logic [31:0]           din_a;
  logic [31:0]           din_b;

  assign sy_in = {vl_mode_pin, chained_hold_request_in, ahold, boff_n,
                  brdy_n, rdyrtn_n, grant_pin, hw_reset_pin};

  // The first stage is read only by the second
  genvar g;
  generate
    for (g = 0; g < `LBM_NSYNC; g++) begin : g_sync
      always_ff @(posedge clk_sys)
      begin
        sy_a[g] <= sy_in[g];
        sy_b[g] <= sy_a[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    din_a <= data_in;
    din_b <= din_a;
  end

  // ==========================================================
  // Decoded bus conditions
  logic vl;
  logic hw_rst;
  logic grant;
  logic rdy;
  logic boff;
  logic ahold_s;
  logic chreq;

  assign vl      = sy_b[`LBM_SY_VLMODE];
  // The alternate mode uses the opposite sense on the reset, grant and hold pins
  assign hw_rst  = sy_b[`LBM_SY_RESET] ^ vl;
  assign grant   = sy_b[`LBM_SY_GRANT] ^ vl;
  assign rdy     = ~sy_b[`LBM_SY_RDYRTN] | ~sy_b[`LBM_SY_BRDY];
  assign boff    = ~sy_b[`LBM_SY_BOFF];
  assign ahold_s = sy_b[`LBM_SY_AHOLD];
  assign chreq   = sy_b[`LBM_SY_CHREQ];

  // ==========================================================
  // Registers
  lbm_pkg::lbm_mstate_e mstate;
  lbm_pkg::lbm_sstate_e sstate;
  logic [15:0]          blctrl;
  logic [15:0]          arbctrl;
  logic                 swr_halt;
  logic                 halt;
  logic                 prio_int;
  logic                 hold_act;
  logic                 preempt_seen;

  assign halt     = arbctrl[`LBM_ARB_STOP_BIT] | swr_halt;
  assign prio_int = arbctrl[`LBM_ARB_PRIO_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || hw_rst)
    begin
      blctrl  <= `LBM_BLCTRL_RST;
      arbctrl <= `LBM_ARBCTRL_RST;
    end
    else if (sstate == lbm_pkg::S_IDLE && slv_sel && slv_wr)
    begin
      if (slv_addr == `LBM_OFF_BLCTRL)
        blctrl <= slv_wdata;
      if (slv_addr == `LBM_OFF_ARBCTRL)
        arbctrl <= slv_wdata;
    end
  end

  // Reading the reset port halts the master; a new read wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || hw_rst)
      swr_halt <= 1'b0;
    else if (sstate == lbm_pkg::S_IDLE && slv_sel && slv_rd &&
             slv_addr == `LBM_OFF_SWRESET)
      swr_halt <= 1'b1;
    else if (mstate == lbm_pkg::M_DROP)
      swr_halt <= 1'b0;
  end

  // ==========================================================
  // Slave machine
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sstate    <= lbm_pkg::S_IDLE;
      slv_rdy_n <= 1'b1;
      slv_rdata <= 16'h0000;
    end
    else
      case (sstate)
        lbm_pkg::S_IDLE:
          if (slv_sel && (slv_rd || slv_wr))
          begin
            sstate    <= lbm_pkg::S_ACK;
            slv_rdy_n <= 1'b0;
            case (slv_addr)
              `LBM_OFF_BLCTRL:  slv_rdata <= blctrl;
              `LBM_OFF_ARBCTRL:
              begin
                slv_rdata <= arbctrl;
                slv_rdata[`LBM_STAT_HOLD_BIT] <= hold_act;
                slv_rdata[`LBM_STAT_HLDA_BIT] <= grant;
              end
              default:          slv_rdata <= 16'h0000;
            endcase
          end
        lbm_pkg::S_ACK:
        begin
          sstate    <= lbm_pkg::S_IDLE;
          slv_rdy_n <= 1'b1;
        end
        default:
        begin
          sstate    <= lbm_pkg::S_IDLE;
          slv_rdy_n <= 1'b1;
        end
      endcase
  end

  // Enable moves half a cycle apart from the value to avoid contention
  always_ff @(negedge clk_sys)
  begin
    if (!reset_n)
      slv_rdy_oe <= 1'b0;
    else
      slv_rdy_oe <= (sstate == lbm_pkg::S_ACK);
  end

  // Claim must answer before the next edge, so it is not registered
  assign slv_claim = slv_sel;

  // ==========================================================
  // Master machine
  lbm_pkg::lbm_op_s cur;
  logic [29:0]      cur_addr;
  logic             second;
  logic [29:0]      lo_grp;
  logic [29:0]      fl_mask;

  assign lo_grp  = low_group(blctrl[`LBM_LINEAR_BURST_COUNT_MSB:`LBM_LINEAR_BURST_COUNT_LSB]);
  assign fl_mask = float_mask(blctrl[`LBM_CLL_MSB:`LBM_CLL_LSB]);

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || hw_rst)
    begin
      // No grant wait: hold falls one cycle after the pin clears the two sync stages
      mstate   <= lbm_pkg::M_IDLE;
      hold_pin <= reset_n ? vl : 1'b0;
      hold_act <= 1'b0;
      chained_hold_ack_out <= 1'b0;
      cur      <= '0;
      cur_addr <= 30'h0;
      second   <= 1'b0;
      op_ack   <= 1'b0;
      op_done  <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= 32'h0;
      ads_n    <= 1'b1;
      wr_out   <= 1'b0;
      be_n_out <= 4'hF;
      ctl_oe   <= 1'b0;
      addr_out <= 30'h0;
      addr_oe  <= 30'h0;
      data_out <= 32'h0;
      data_oe  <= 1'b0;
    end
    else
    begin
      op_ack   <= 1'b0;
      op_done  <= 1'b0;
      rd_valid <= 1'b0;
      case (mstate)
        lbm_pkg::M_IDLE:
        begin
          if (op_valid && !halt && !(chreq && !prio_int))
          begin
            cur      <= op;
            cur_addr <= op.addr;
            second   <= 1'b0;
            op_ack   <= 1'b1;
            hold_pin <= ~vl;
            hold_act <= 1'b1;
            mstate   <= lbm_pkg::M_REQ;
          end
          else if (chreq)
          begin
            hold_pin <= ~vl;
            hold_act <= 1'b1;
            mstate   <= lbm_pkg::M_CHAIN;
          end
        end
        lbm_pkg::M_CHAIN:
        begin
          chained_hold_ack_out <= grant && chreq;
          if (!chreq)
          begin
            hold_pin <= vl;
            hold_act <= 1'b0;
            mstate   <= lbm_pkg::M_IDLE;
          end
        end
        lbm_pkg::M_REQ:
          if (grant)
          begin
            if (halt)
            begin
              // Brief ownership with no access performed
              hold_pin <= vl;
              hold_act <= 1'b0;
              mstate   <= lbm_pkg::M_DROP;
            end
            else
              mstate <= lbm_pkg::M_ADDR;
          end
        lbm_pkg::M_ADDR:
          if (!ahold_s && !boff)
          begin
            ads_n    <= 1'b0;
            ctl_oe   <= 1'b1;
            wr_out   <= cur.write;
            be_n_out <= ~cur.be;
            addr_out <= cur_addr;
            addr_oe  <= 30'h3FFFFFFF;
            data_out <= second ? cur.wdata1 : cur.wdata0;
            data_oe  <= cur.write;
            mstate   <= lbm_pkg::M_DATA;
          end
          else
          begin
            ads_n <= 1'b1;
            if (boff)
            begin
              // A pending second transfer must not keep driving the bus
              ctl_oe  <= 1'b0;
              addr_oe <= 30'h0;
              data_oe <= 1'b0;
            end
          end
        lbm_pkg::M_DATA:
        begin
          ads_n <= 1'b1;
          if (boff)
          begin
            // Ready in this cycle is discarded
            ctl_oe  <= 1'b0;
            addr_oe <= 30'h0;
            data_oe <= 1'b0;
            mstate  <= lbm_pkg::M_BOFF;
          end
          else if (rdy)
          begin
            // Ready ends the cycle even while address hold floats lines
            rd_data  <= din_b;
            rd_valid <= ~cur.write;
            data_oe  <= 1'b0;
            if (!cur.two || second)
            begin
              // Preemption never cuts an operation short
              op_done  <= 1'b1;
              hold_pin <= vl;
              hold_act <= 1'b0;
              ctl_oe   <= 1'b0;
              addr_oe  <= 30'h0;
              mstate   <= lbm_pkg::M_IDLE;
            end
            else
            begin
              second <= 1'b1;
              if (cur.linear)
                cur_addr <= (cur_addr & ~lo_grp) |
                            ((cur_addr + 30'h1) & lo_grp);
              else
                cur_addr <= cur_addr + 30'h1;
              mstate <= lbm_pkg::M_ADDR;
            end
          end
          else if (ahold_s)
            addr_oe <= ~fl_mask;
          else
            addr_oe <= 30'h3FFFFFFF;
        end
        lbm_pkg::M_BOFF:
          if (!boff)
            mstate <= lbm_pkg::M_ADDR;
        lbm_pkg::M_DROP:
          mstate <= lbm_pkg::M_IDLE;
        default:
          mstate <= lbm_pkg::M_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Preemption is only noted in preempt_seen, which no output or status read shows; the operation completes
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || mstate == lbm_pkg::M_IDLE)
      preempt_seen <= 1'b0;
    else if (preempt)
      preempt_seen <= 1'b1;
  end

endmodule : lbm_bus_master

// [lbm_bus_master_properties.sv]
// ==========================================
// Port checks for the bus master
module lbm_bus_master_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // Slave port
  input wire logic        slv_sel,
  input wire logic        slv_rd,
  input wire logic        slv_wr,
  input wire logic        slv_rdy_n,
  input wire logic        slv_rdy_oe,
  input wire logic        slv_claim,
  // Master side
  input wire logic        op_ack,
  input wire logic        op_done,
  input wire logic        hw_reset_pin,
  input wire logic        vl_mode_pin,
  input wire logic        hold_pin,
  input wire logic        chained_hold_request_in,
  input wire logic        chained_hold_ack_out,
  input wire logic        boff_n,
  input wire logic        ahold,
  input wire logic        ads_n,
  input wire logic        ctl_oe,
  input wire logic [31:2] addr_oe,
  input wire logic        data_oe
);
  // Pin sense flips in the alternate bus mode
  wire logic hold_act = hold_pin ^ vl_mode_pin;
  wire logic hw_act   = hw_reset_pin ^ vl_mode_pin;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  chk_claim_follow:
    assert property (slv_claim == slv_sel)
    else $error("claim differs from select");
  chk_slave_answer:
    assert property (slv_sel && (slv_rd || slv_wr) && slv_rdy_n
      |=> !slv_rdy_n ##1 slv_rdy_n)
    else $error("slave ready missing or too long");
  chk_ready_enable:
    assert property ($fell(slv_rdy_n) |-> slv_rdy_oe && !$past(slv_rdy_oe))
    else $error("ready enable not switched between edges");
  chk_strobe_single:
    assert property (!ads_n |-> ctl_oe ##1 ads_n)
    else $error("address strobe malformed");
  chk_hold_on_ack:
    assert property (op_ack |-> hold_act)
    else $error("op taken without hold");
  chk_done_release:
    assert property (op_done |-> !hold_act)
    else $error("hold kept after last ready");
  chk_boff_float:
    assert property (!boff_n [*5] |-> !ctl_oe && !data_oe && addr_oe == '0)
    else $error("bus driven under backoff");
  chk_ahold_block:
    assert property (ahold [*5] |-> ads_n)
    else $error("new cycle under address hold");
  chk_hw_drop:
    assert property ($rose(hw_act) |-> ##[1:6] !hold_act)
    else $error("hold kept after hardware reset");
  chk_chain_ack:
    assert property (chained_hold_ack_out |->
      $past(chained_hold_request_in, 3))
    else $error("chained ack without request");
endmodule : lbm_bus_master_props

bind lbm_bus_master lbm_bus_master_props lbm_bus_master_props_i (
  .clk_sys, .reset_n, .slv_sel, .slv_rd, .slv_wr, .slv_rdy_n, .slv_rdy_oe,
  .slv_claim, .op_ack, .op_done, .hw_reset_pin, .vl_mode_pin, .hold_pin,
  .chained_hold_request_in, .chained_hold_ack_out, .boff_n, .ahold,
  .ads_n, .ctl_oe, .addr_oe, .data_oe
);

// [lbm_far_model.sv]
// ==========================================
// Arbiter and memory target on the far side
module lbm_far_model (
  // Clock
  input  wire logic        clk_sys,
  // From the bus master
  input  wire logic        hold_pin,
  input  wire logic        ads_n,
  input  wire logic        wr_out,
  input  wire logic [31:2] addr_out,
  input  wire logic [31:0] data_out,
  // Answers
  output logic             grant_pin,
  output logic             rdyrtn_n,
  output logic [31:0]      data_in,
  // Speed of the answers
  input  wire logic [3:0]  n_gnt,
  input  wire logic [3:0]  n_wait
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  gcnt = 4'h0;
  logic [3:0]  wcnt = 4'h0;
  logic        busy = 1'b0;
  logic        wr_q = 1'b0;
  logic [31:2] last_a = '0;
  logic [31:0] last_d = '0;
  int          n_ads = 0;
  initial
  begin
    grant_pin = 1'b0;
    rdyrtn_n = 1'b1;
    data_in = 32'h0;
  end
  // Grant after a set delay, withdrawn as soon as hold goes
  always @(posedge clk_sys)
    if (hold_pin !== 1'b1)
    begin
      grant_pin <= 1'b0;
      gcnt <= 4'h0;
    end
    else if (gcnt == n_gnt)
      grant_pin <= 1'b1;
    else
      gcnt <= gcnt + 4'h1;
  // Keeps counting under backoff, so a ready can collide with it
  always @(posedge clk_sys)
  begin
    rdyrtn_n <= 1'b1;
    data_in <= ~data_in;
    if (ads_n === 1'b0)
    begin
      busy <= 1'b1;
      wcnt <= 4'h0;
      wr_q <= wr_out;
      last_a <= addr_out;
      n_ads <= n_ads + 1;
    end
    else if (busy && wcnt == n_wait)
    begin
      busy <= 1'b0;
      rdyrtn_n <= 1'b0;
      data_in <= {last_a, 2'b00} ^ 32'h5A5A0F0F;
      if (wr_q)
        last_d <= data_out;
    end
    else if (busy)
      wcnt <= wcnt + 4'h1;
  end
endmodule : lbm_far_model

// [tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Signals
  logic             clk_sys = 1'b0;
  logic             reset_n, slv_sel, slv_rd, slv_wr, op_valid, preempt;
  logic             hw_reset_pin, grant_pin, chained_hold_request_in;
  logic             rdyrtn_n, boff_n, ahold, slv_rdy_n, slv_rdy_oe;
  logic             slv_claim, op_ack, op_done, rd_valid, hold_pin;
  logic             chained_hold_ack_out, ads_n, wr_out, ctl_oe, data_oe;
  logic [4:0]       slv_addr;
  logic [4:0]       codes[6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  logic [15:0]      slv_wdata, slv_rdata, q;
  logic [3:0]       be_n_out, n_wait, n_gnt;
  logic [31:0]      rd_data, data_out, data_in;
  logic [31:2]      addr_out, addr_oe;
  lbm_pkg::lbm_op_s op;
  logic [31:0]      rd_q[$];
  int               n_fail = 0, checked = 0, cyc = 0, n, a0;
  always #25 clk_sys = ~clk_sys;
  // Alternate mode and burst ready stay unused here
  lbm_bus_master lbm_bus_master_i (.clk_sys, .reset_n, .slv_sel, .slv_rd,
    .slv_wr, .slv_addr, .slv_wdata, .slv_rdata, .slv_rdy_n, .slv_rdy_oe,
    .slv_claim, .op_valid, .op, .preempt, .op_ack, .op_done, .rd_data,
    .rd_valid, .hw_reset_pin, .vl_mode_pin(1'b0), .grant_pin, .hold_pin,
    .chained_hold_request_in, .chained_hold_ack_out, .rdyrtn_n,
    .brdy_n(1'b1), .boff_n, .ahold, .ads_n, .wr_out, .be_n_out, .ctl_oe,
    .addr_out, .addr_oe, .data_out, .data_oe, .data_in);
  lbm_far_model lbm_far_model_i (.clk_sys, .hold_pin, .ads_n, .wr_out,
    .addr_out, .data_out, .grant_pin, .rdyrtn_n, .data_in, .n_gnt, .n_wait);
  // ==========================================
  // Tasks
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic slv(input logic w, input logic [4:0] a,
                     input logic [15:0] d);
    @(posedge clk_sys);
    slv_sel <= 1'b1;
    slv_rd <= ~w;
    slv_wr <= w;
    slv_addr <= a;
    slv_wdata <= d;
    @(posedge clk_sys);
    for (n = 0; slv_rdy_n !== 1'b0 && n < 9; n++)
      @(posedge clk_sys);
    q = slv_rdata;
    slv_sel <= 1'b0;
    slv_rd <= 1'b0;
    slv_wr <= 1'b0;
    cmp(32'(n < 9), 32'h1);
  endtask : slv
  task automatic issue(input logic w, lin, two, input logic [29:0] a);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op <= '{w, lin, two, a, 4'hF, 32'hC0DE0001, 32'hC0DE0002};
    @(posedge clk_sys);
    for (n = 0; op_ack !== 1'b1 && n < 9; n++)
      @(posedge clk_sys);
    op_valid <= 1'b0;
  endtask : issue
  task automatic run(input logic w, lin, two, input logic [29:0] a);
    issue(w, lin, two, a);
    for (n = 0; op_done !== 1'b1 && n < 60; n++)
      @(posedge clk_sys);
    cmp(32'(n < 60), 32'h1);
    repeat (2) @(posedge clk_sys);
  endtask : run
  function automatic logic [31:0] pat(input logic [29:0] a);
    return {a, 2'b00} ^ 32'h5A5A0F0F;
  endfunction : pat
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rd_valid === 1'b1)
      rd_q.push_back(rd_data);
    if (cyc == 5000)
    begin
      n_fail++;
      wrap_up;
    end
  end
  // ==========================================
  // Sequence
  initial
  begin
    {reset_n, slv_sel, slv_rd, slv_wr, op_valid, preempt} = '0;
    {hw_reset_pin, chained_hold_request_in, ahold} = '0;
    {slv_addr, slv_wdata, op} = '0;
    boff_n = 1'b1;
    n_wait = 4'h2;
    n_gnt = 4'h1;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    slv(1'b0, 5'h18, 16'h0000);
    cmp(32'(q), 32'h2000);
    slv(1'b0, 5'h1C, 16'h0000);
    cmp(32'(q), 32'h0000);
    slv(1'b0, 5'h04, 16'h0000);
    preempt <= 1'b1;
    run(1'b0, 1'b0, 1'b1, 30'h100);
    cmp(32'(rd_q.size()), 32'h2);
    cmp(rd_q[0], pat(30'h100));
    cmp(rd_q[1], pat(30'h101));
    preempt <= 1'b0;
    slv(1'b1, 5'h18, 16'h2001);
    run(1'b1, 1'b1, 1'b1, 30'h201);
    cmp(32'(lbm_far_model_i.last_a), 32'h200);
    cmp(lbm_far_model_i.last_d, 32'hC0DE0002);
    n_wait <= 4'h3;
    rd_q.delete();
    a0 = lbm_far_model_i.n_ads;
    fork
      run(1'b0, 1'b0, 1'b0, 30'h300);
      begin
        @(negedge ads_n);
        @(posedge clk_sys);
        boff_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        boff_n <= 1'b1;
      end
    join
    cmp(32'(lbm_far_model_i.n_ads - a0), 32'h2);
    cmp(32'(rd_q.size()), 32'h1);
    cmp(rd_q[0], pat(30'h300));
    n_wait <= 4'hF;
    foreach (codes[i])
    begin
      slv(1'b1, 5'h18, {codes[i], 11'h000});
      a0 = lbm_far_model_i.n_ads;
      fork
        run(1'b0, 1'b0, 1'b0, 30'h3FF);
        begin
          @(negedge ads_n);
          @(posedge clk_sys);
          ahold <= 1'b1;
          repeat (5) @(posedge clk_sys);
          cmp(32'(addr_oe), codes[i] == 5'h00 ? 32'h3FFFFFFF
              : 32'(codes[i]) - 32'h1);
          ahold <= 1'b0;
          repeat (4) @(posedge clk_sys);
          cmp(32'(addr_oe), 32'h3FFFFFFF);
        end
      join
      cmp(32'(lbm_far_model_i.n_ads - a0), 32'h1);
    end
    chained_hold_request_in <= 1'b1;
    for (n = 0; chained_hold_ack_out !== 1'b1 && n < 20; n++)
      @(posedge clk_sys);
    cmp(32'(n < 20), 32'h1);
    chained_hold_request_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    n_gnt <= 4'h8;
    issue(1'b0, 1'b0, 1'b0, 30'h40);
    hw_reset_pin <= 1'b1;
    @(posedge clk_sys);
    hw_reset_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cmp(32'(hold_pin), 32'h0);
    repeat (3) @(posedge clk_sys);
    slv(1'b0, 5'h18, 16'h0000);
    cmp(32'(q), 32'h2000);
    a0 = lbm_far_model_i.n_ads;
    issue(1'b0, 1'b0, 1'b0, 30'h40);
    slv(1'b0, 5'h14, 16'h0000);
    cmp(32'(q), 32'h0);
    cmp(32'(hold_pin), 32'h1);
    for (n = 0; hold_pin !== 1'b0 && n < 30; n++)
      @(posedge clk_sys);
    cmp(32'(n < 30), 32'h1);
    cmp(32'(lbm_far_model_i.n_ads - a0), 32'h0);
    wrap_up;
  end
endmodule : tb
